// ### fwws_pkg.sv
// fwws_pkg: constants and types for the flash word write sequencer
// assumes an apb slave at 32-bit aligned words, 100 MHz pclk
package fwws_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] off_table_pointer_upper = 8'h00;
  localparam logic [7:0] off_table_pointer_high  = 8'h04;
  localparam logic [7:0] off_table_pointer_low   = 8'h08;
  localparam logic [7:0] off_table_data_latch    = 8'h0c;
  localparam logic [7:0] off_interrupt_control   = 8'h10;
  localparam logic [7:0] off_flash_unlock_port   = 8'h14;
  localparam logic [7:0] off_flash_control       = 8'h18;
  localparam logic [7:0] off_table_write_op      = 8'h1c;
  localparam logic [7:0] off_irq_status          = 8'h20;
  localparam logic [7:0] off_irq_mask            = 8'h24;

  // ---------------------------------------------------------------
  // flash control bit positions
  // ---------------------------------------------------------------
  localparam int bit_word_program_select = 5;
  localparam int bit_erase_select        = 4;
  localparam int bit_write_error_flag    = 3;
  localparam int bit_write_permit_bit    = 2;
  localparam int bit_write_start         = 1;
  localparam logic [7:0] flash_control_mask = 8'h3e;
  localparam int bit_global_interrupt_enable = 7;

  // table write op: bit 0 asks for post increment
  localparam int bit_table_post_inc = 0;

  // interrupt status bits
  localparam int irq_write_done  = 0;
  localparam int irq_write_error = 1;
  localparam int irq_width       = 2;

  // ---------------------------------------------------------------
  // unlock keys, reset values, timing
  // ---------------------------------------------------------------
  localparam logic [7:0] unlock_key_first  = 8'h55;
  localparam logic [7:0] unlock_key_second = 8'haa;
  localparam logic [7:0] reset_byte        = 8'h00;
  localparam logic [20:0] reset_pointer    = 21'h000000;
  localparam int clk_mhz                   = 100;
  localparam int write_time_us             = 2;
  localparam int write_cycles              = write_time_us * clk_mhz;
  localparam logic [15:0] write_cycles_c   = 16'(write_cycles);
  localparam int holding_bytes             = 64;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    key_idle,
    key_first_seen,
    key_armed
  } fwws_key_type;

  // one word program request handed to the flash macro
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
  } fwws_word_type;

endpackage : fwws_pkg

// ### fwws_timer.sv
// fwws_timer: internally timed program cycle for one word
// assumes start is a one-cycle pulse and abort is a reset event
module fwws_timer
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        start,
  input  wire logic        abort,
  // status
  output logic             busy,
  output logic             done
);

  logic [15:0] count_r;

  // ---------------------------------------------------------------
  // write cycle counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= 16'h0000;
      busy    <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        count_r <= 16'h0000;
        busy    <= 1'b0;
      end
      else if (start && !busy)
      begin
        count_r <= fwws_pkg::write_cycles_c - 16'h0001;
        busy    <= 1'b1;
      end
      else if (busy)
      begin
        if (count_r == 16'h0000)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          count_r <= count_r - 16'h0001;
        end
      end
    end
  end

endmodule : fwws_timer

// ### fwws_seq.sv
// fwws_seq: flash word write sequencer with apb register slave
// assumes apb master on pclk; cpu honours cpu_stall; flash macro
// takes a one-cycle prog strobe with address and word
//
// Behaviour
// - word select set programs one two-byte word, not a whole row.
// - start begins the timed write and stalls the cpu until it ends.
// - a master clear or watchdog reset mid write sets the error flag.
// - control holds bits 5 to 1 as listed, bits 7, 6 and 0 read zero.
// - the unlock port stores nothing and reads as zero.
// - the table pointer is split into upper, high and low bytes.
// - holding registers are not cleared after a write.
module fwws_seq
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system reset causes, pulses
  input  wire logic        master_clear_reset,
  input  wire logic        watchdog_timer,
  // flash and cpu side
  output logic             cpu_stall,
  output logic             prog_strobe,
  output fwws_pkg::fwws_word_type prog_word,
  output logic             irq
);

  logic [20:0] table_pointer_r;
  logic [7:0]  table_data_latch_r;
  logic [7:0]  interrupt_control_r;
  logic [7:0]  flash_control_r;
  localparam int irq_w_m = fwws_pkg::irq_width - 1;
  logic [7:0]  hold_r [fwws_pkg::holding_bytes];
  logic [irq_w_m:0] irq_status_r;
  logic [irq_w_m:0] irq_mask_r;
  fwws_pkg::fwws_key_type key_r;
  logic        start_req;
  logic        busy;
  logic        done;
  logic        wr_en;
  logic        rd_en;
  logic        write_abort;
  logic [fwws_pkg::irq_width-1:0] irq_set;

  // address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ---------------------------------------------------------------
  // apb access strobes
  // ---------------------------------------------------------------
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign write_abort = busy && (master_clear_reset || watchdog_timer);
  assign irq_set[fwws_pkg::irq_write_done]  = done;
  assign irq_set[fwws_pkg::irq_write_error] = write_abort;

  // request is legal only after permit and both keys
  assign start_req = wr_en && hit(paddr, fwws_pkg::off_flash_control)
    && pwdata[fwws_pkg::bit_write_start]
    && flash_control_r[fwws_pkg::bit_write_permit_bit]
    && (key_r == fwws_pkg::key_armed) && !busy;

  // ---------------------------------------------------------------
  // table pointer and latch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      table_pointer_r    <= fwws_pkg::reset_pointer;
      table_data_latch_r <= fwws_pkg::reset_byte;
    end
    else if (wr_en)
    begin
      if (hit(paddr, fwws_pkg::off_table_pointer_upper))
        table_pointer_r[20:16] <= pwdata[4:0];
      if (hit(paddr, fwws_pkg::off_table_pointer_high))
        table_pointer_r[15:8] <= pwdata[7:0];
      if (hit(paddr, fwws_pkg::off_table_pointer_low))
        table_pointer_r[7:0] <= pwdata[7:0];
      if (hit(paddr, fwws_pkg::off_table_data_latch))
        table_data_latch_r <= pwdata[7:0];
      if (hit(paddr, fwws_pkg::off_table_write_op)
          && pwdata[fwws_pkg::bit_table_post_inc])
        table_pointer_r <= table_pointer_r + 21'h000001;
    end
  end

  // ---------------------------------------------------------------
  // holding registers, never cleared by a write cycle
  // ---------------------------------------------------------------
  for (genvar g = 0; g < fwws_pkg::holding_bytes; g++)
  begin : g_hold
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        hold_r[g] <= fwws_pkg::reset_byte;
      else if (wr_en && hit(paddr, fwws_pkg::off_table_write_op)
               && (table_pointer_r[5:0] == 6'(g)))
        hold_r[g] <= table_data_latch_r;
    end
  end

  // ---------------------------------------------------------------
  // unlock key detection, no storage readable
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      key_r <= fwws_pkg::key_idle;
    else if (wr_en)
    begin
      case (key_r)
        fwws_pkg::key_idle:
          if (hit(paddr, fwws_pkg::off_flash_unlock_port)
              && pwdata[7:0] == fwws_pkg::unlock_key_first)
            key_r <= fwws_pkg::key_first_seen;
        fwws_pkg::key_first_seen:
          if (hit(paddr, fwws_pkg::off_flash_unlock_port)
              && pwdata[7:0] == fwws_pkg::unlock_key_second)
            key_r <= fwws_pkg::key_armed;
          else
            key_r <= fwws_pkg::key_idle;
        fwws_pkg::key_armed:
          key_r <= fwws_pkg::key_idle; // only the very next write
        default:
          key_r <= fwws_pkg::key_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flash control register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flash_control_r <= fwws_pkg::reset_byte;
    else
    begin
      if (wr_en && hit(paddr, fwws_pkg::off_flash_control))
      begin
        flash_control_r[5:2] <= pwdata[5:2];
        flash_control_r[fwws_pkg::bit_write_error_flag] <=
          pwdata[fwws_pkg::bit_write_error_flag];
      end
      // clear first, so a start in the same cycle as done still wins
      if (done || write_abort)
        flash_control_r[fwws_pkg::bit_write_start] <= 1'b0;
      if (start_req)
        flash_control_r[fwws_pkg::bit_write_start] <= 1'b1;
      if (write_abort)
        flash_control_r[fwws_pkg::bit_write_error_flag] <= 1'b1;
    end
  end

  // interrupt control byte, plain storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_control_r <= fwws_pkg::reset_byte;
    else if (wr_en && hit(paddr, fwws_pkg::off_interrupt_control))
      interrupt_control_r <= pwdata[7:0];
  end

  // ---------------------------------------------------------------
  // write cycle timer and flash strobe
  // ---------------------------------------------------------------
  fwws_timer u_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start_req),
    .abort   (write_abort),
    .busy    (busy),
    .done    (done)
  );

  // word mode programs two bytes at the even address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_strobe <= 1'b0;
      prog_word   <= '0;
      cpu_stall   <= 1'b0;
    end
    else
    begin
      prog_strobe <= start_req
        && flash_control_r[fwws_pkg::bit_word_program_select];
      if (start_req)
      begin
        prog_word.addr <= {table_pointer_r[20:1], 1'b0};
        prog_word.data <= {hold_r[{table_pointer_r[5:1], 1'b1}],
                           hold_r[{table_pointer_r[5:1], 1'b0}]};
      end
      cpu_stall <= start_req || (busy && !done && !write_abort);
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, set wins over write-one clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_r <= '0;
      irq_mask_r   <= '0;
      irq          <= 1'b0;
    end
    else
    begin
      if (wr_en && hit(paddr, fwws_pkg::off_irq_status))
        irq_status_r <= (irq_status_r & ~pwdata[irq_w_m:0]) | irq_set;
      else
        irq_status_r <= irq_status_r | irq_set;
      if (wr_en && hit(paddr, fwws_pkg::off_irq_mask))
        irq_mask_r <= pwdata[irq_w_m:0];
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // apb read data, ready and error
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr <= fwws_pkg::off_irq_mask
                 && paddr[1:0] == 2'b00);
      if (rd_en)
      begin
        case (paddr)
          fwws_pkg::off_table_pointer_upper:
            prdata <= {27'h0000000, table_pointer_r[20:16]};
          fwws_pkg::off_table_pointer_high:
            prdata <= {24'h000000, table_pointer_r[15:8]};
          fwws_pkg::off_table_pointer_low:
            prdata <= {24'h000000, table_pointer_r[7:0]};
          fwws_pkg::off_table_data_latch:
            prdata <= {24'h000000, table_data_latch_r};
          fwws_pkg::off_interrupt_control:
            prdata <= {24'h000000, interrupt_control_r};
          fwws_pkg::off_flash_control:
            prdata <= {24'h000000,
                       flash_control_r & fwws_pkg::flash_control_mask};
          fwws_pkg::off_irq_status:
            prdata <= {30'h00000000, irq_status_r};
          fwws_pkg::off_irq_mask:
            prdata <= {30'h00000000, irq_mask_r};
          default:
            prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : fwws_seq

// ### fwws_seq_checker.sv
// fwws_seq_checker: port assertions for the word write sequencer
// assumes one pclk domain and presetn async active low
module fwws_seq_checker
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // reset causes and flash side
  input wire logic        master_clear_reset,
  input wire logic        watchdog_timer,
  input wire logic        cpu_stall,
  input wire logic        prog_strobe,
  input wire fwws_pkg::fwws_word_type prog_word
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [8:0] cnt_r; // stall cycles so far
  logic       cut_r; // abort seen in this stall
  // stall length and abort tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 9'h000;
      cut_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cpu_stall ? cnt_r + 9'h001 : 9'h000;
      cut_r <= cpu_stall & (cut_r | master_clear_reset | watchdog_timer);
    end
  end
  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready : assert property (p_ready) else $error("no ready after setup");
  property p_ready_acc;
    pready |-> psel && penable;
  endproperty
  a_ready_acc : assert property (p_ready_acc) else $error("stray ready");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err : assert property (p_err) else $error("error without ready");
  property p_pulse;
    prog_strobe |=> !prog_strobe;
  endproperty
  a_pulse : assert property (p_pulse) else $error("strobe too long");
  property p_even;
    prog_strobe |-> cpu_stall && !prog_word.addr[0];
  endproperty
  a_even : assert property (p_even) else $error("odd or no stall");
  property p_cause;
    prog_strobe |-> $past(psel && penable && pwrite && !cpu_stall
      && paddr == fwws_pkg::off_flash_control && pwdata[1]);
  endproperty
  a_cause : assert property (p_cause) else $error("unasked start");
  property p_len;
    $fell(cpu_stall) && !cut_r |-> cnt_r inside {[199:201]};
  endproperty
  a_len : assert property (p_len) else $error("bad write time");
  property p_abort;
    cpu_stall && (master_clear_reset || watchdog_timer) |-> ##[1:3] !cpu_stall;
  endproperty
  a_abort : assert property (p_abort) else $error("abort ignored");
  c_start : cover property (prog_strobe);
  c_cut   : cover property (cpu_stall && watchdog_timer);
  c_err   : cover property (pslverr);
endmodule : fwws_seq_checker

bind fwws_seq fwws_seq_checker u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .master_clear_reset(master_clear_reset),
  .watchdog_timer(watchdog_timer), .cpu_stall(cpu_stall),
  .prog_strobe(prog_strobe), .prog_word(prog_word)
);

// ### tb_top.sv
// tb_top: apb register tests of the word write sequencer
// assumes fwws_seq answers one access cycle after setup
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        master_clear_reset = 1'b0;
  logic        watchdog_timer = 1'b0;
  logic        cpu_stall;
  logic        prog_strobe;
  logic        irq;
  logic [31:0] rd_v;
  logic        er_v;
  int          failures = 0;
  int          compares = 0;
  int          n_strobe = 0;
  int          cyc = 0;
  fwws_pkg::fwws_word_type prog_word;
  fwws_pkg::fwws_word_type word_s;
  // -------------------------------------------------------------
  // clock, timeout, strobe monitor
  // -------------------------------------------------------------
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      report_and_stop();
    end
    if (prog_strobe === 1'b1)
    begin
      n_strobe <= n_strobe + 1;
      word_s   <= prog_word;
    end
  end
  fwws_seq uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .master_clear_reset(master_clear_reset),
    .watchdog_timer(watchdog_timer), .cpu_stall(cpu_stall),
    .prog_strobe(prog_strobe), .prog_word(prog_word), .irq(irq)
  );
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, result left in rd_v and er_v
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(40'(rd_v), 40'(e));
  endtask : rd
  // permit, keys, start; optional reset cause mid write
  task automatic go(input int cut);
    int n;
    apb(1'b1, fwws_pkg::off_flash_control, 8'h24);
    apb(1'b1, fwws_pkg::off_interrupt_control, 8'h00);
    apb(1'b1, fwws_pkg::off_flash_unlock_port, 8'h55);
    apb(1'b1, fwws_pkg::off_flash_unlock_port, 8'haa);
    apb(1'b1, fwws_pkg::off_flash_control, 8'h26);
    @(posedge pclk);
    chk(40'(cpu_stall), 40'h1);
    if (cut != 0)
    begin
      repeat (20) @(posedge pclk);
      master_clear_reset <= (cut == 1);
      watchdog_timer     <= (cut == 2);
      @(posedge pclk);
      master_clear_reset <= 1'b0;
      watchdog_timer     <= 1'b0;
    end
    n = 0;
    while (cpu_stall === 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    if (cut == 0)
      chk(40'(n >= 199 && n <= 201), 40'h1);
    apb(1'b1, fwws_pkg::off_interrupt_control, 8'h80);
    rd(fwws_pkg::off_interrupt_control, 8'h80);
  endtask : go
  task automatic report_and_stop;
    $display("TB: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // -------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(fwws_pkg::off_flash_control, 8'h00);
    apb(1'b1, fwws_pkg::off_flash_control, 8'hf5);
    rd(fwws_pkg::off_flash_control, 8'h34);
    rd(fwws_pkg::off_flash_unlock_port, 8'h00);
    apb(1'b0, 8'h30, 8'h00);
    chk(40'({er_v, rd_v}), 40'h100000000);
    $display("test control done");
    apb(1'b1, fwws_pkg::off_flash_control, 8'h24);
    apb(1'b1, fwws_pkg::off_flash_control, 8'h26);
    apb(1'b1, fwws_pkg::off_flash_unlock_port, 8'h55);
    apb(1'b1, fwws_pkg::off_table_pointer_low, 8'h44);
    apb(1'b1, fwws_pkg::off_flash_unlock_port, 8'haa);
    apb(1'b1, fwws_pkg::off_flash_control, 8'h26);
    apb(1'b1, fwws_pkg::off_flash_control, 8'h20);
    apb(1'b1, fwws_pkg::off_flash_unlock_port, 8'h55);
    apb(1'b1, fwws_pkg::off_flash_unlock_port, 8'haa);
    apb(1'b1, fwws_pkg::off_flash_control, 8'h22);
    repeat (3) @(posedge pclk);
    chk(40'(n_strobe), 40'h0);
    $display("test refusal done");
    apb(1'b1, fwws_pkg::off_table_pointer_upper, 8'h01);
    apb(1'b1, fwws_pkg::off_table_pointer_high, 8'h23);
    rd(fwws_pkg::off_table_pointer_upper, 8'h01);
    rd(fwws_pkg::off_table_pointer_high, 8'h23);
    apb(1'b1, fwws_pkg::off_table_data_latch, 8'hc3);
    rd(fwws_pkg::off_table_data_latch, 8'hc3);
    apb(1'b1, fwws_pkg::off_table_write_op, 8'h01);
    rd(fwws_pkg::off_table_pointer_low, 8'h45);
    apb(1'b1, fwws_pkg::off_table_data_latch, 8'h5a);
    apb(1'b1, fwws_pkg::off_table_write_op, 8'h00);
    rd(fwws_pkg::off_table_pointer_low, 8'h45);
    go(0);
    chk(40'({n_strobe[2:0], word_s}), {3'h1, 21'h012344, 16'h5ac3});
    rd(fwws_pkg::off_flash_control, 8'h24);
    chk(40'(irq), 40'h0);
    rd(fwws_pkg::off_irq_status, 8'h01);
    apb(1'b1, fwws_pkg::off_irq_mask, 8'h03);
    repeat (2) @(posedge pclk);
    chk(40'(irq), 40'h1);
    apb(1'b1, fwws_pkg::off_irq_status, 8'h01);
    repeat (2) @(posedge pclk);
    chk(40'(irq), 40'h0);
    $display("test word write done");
    apb(1'b1, fwws_pkg::off_table_pointer_high, 8'h24);
    go(0);
    chk(40'({n_strobe[2:0], word_s}), {3'h2, 21'h012444, 16'h5ac3});
    apb(1'b1, fwws_pkg::off_irq_status, 8'h01);
    $display("test holding kept done");
    for (int k = 1; k <= 2; k++)
    begin
      go(k);
      rd(fwws_pkg::off_flash_control, 8'h2c);
      rd(fwws_pkg::off_irq_status, 8'h02);
      chk(40'(irq), 40'h1);
      apb(1'b1, fwws_pkg::off_irq_status, 8'h03);
      apb(1'b1, fwws_pkg::off_flash_control, 8'h00);
    end
    $display("test abort done");
    report_and_stop();
  end
endmodule : tb_top
